// file: hdl/gdfp_gating.sv
// Purpose: Fault supervision and PWM gating of a gate driver channel
// Assumes: Serial clock idles between frames; sense codes on i_clk
// Notes: Serial link checked on its own clock, results read at frame end
`timescale 1ns/1ps
`default_nettype none
`include "gdfp_consts.svh"
// Function
// - Low fail-safe enable input blocks gate drive; high lets PWM through.
// - Configuration mode bit at 1 suppresses PWM; back to 0 resumes.
// - Delayed gate voltage fault latches in status two and locks out PWM.
// - Gate voltage fault mask bit at 0 stops that fault taking effect.
// - Short circuit latches in status one, disables PWM, has no mask.
// - Short circuit threshold and filter time come from its configuration.
// - Enforce dead time; flag violations in status two, still enforcing.
// - Dead time value is configurable; its fault is maskable in mask two.
// - Overcurrent latches in status one, leaves PWM running, has no mask.
// - Overcurrent threshold and filter come from its configuration.
// - One die ready long before the other sets the watchdog fault.
// - Serial frames are multiples of 24 clocks; otherwise flag serial error.
// - Open bus or undriven chip select at start-up flags serial error.
// - Status faults clear by software; masks written only in configuration mode.
// - Status three shows the current fail-safe enable level.
// - A frame with a bad CRC flags serial error.
// - Chip select high gap under 19 us before next frame flags serial error.
module gdfp_gating
  import gdfp_pkg::*;
#(
  parameter int CS_GAP_CYC = (`GDFP_CS_GAP_NS + `GDFP_CLK_NS - 1) / `GDFP_CLK_NS,
  parameter int WDOG_CYC = `GDFP_WDOG_CYC
) (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // PWM and fail-safe pins
  input wire logic i_pwm,
  input wire logic i_pwm_alt,
  input wire logic i_failsafe_enable_n,
  // Analog monitors
  input wire logic i_gate_voltage_monitor,
  input wire logic [7:0] i_current_code,
  input wire logic i_die_low_ready,
  input wire logic i_die_high_ready,
  // Serial link pins
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_mosi,
  // Mode and configuration writes
  input wire logic i_mode_wr,
  input wire logic i_mode_config_en,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_overcurrent_thr,
  input wire logic [7:0] i_overcurrent_filt,
  input wire logic [7:0] i_short_circuit_thr,
  input wire logic [7:0] i_short_circuit_filt,
  input wire logic [7:0] i_dead_time_config,
  input wire logic [7:0] i_gate_monitor_config,
  input wire logic i_mask_wr,
  input wire logic [1:0] i_fault_mask_two,
  // Fault clears, one bit per flag
  input wire logic [1:0] i_clear_one,
  input wire logic [3:0] i_clear_two,
  // Gate drive and status
  output logic o_gate,
  output logic o_mode_control_two,
  output logic [1:0] o_fault_mask_two,
  output logic [1:0] o_fault_status_one,
  output logic [3:0] o_fault_status_two,
  output logic [0:0] o_fault_status_three
);
  //////////////////////////////////////////////////////////////////////
  // Configuration state
  gdfp_code_t oc_thr;
  gdfp_code_t oc_filt;
  gdfp_code_t sc_thr;
  gdfp_code_t sc_filt;
  gdfp_code_t dead;
  gdfp_code_t vge_dly;
  logic cfg_mode;
  logic [1:0] msk;

  // Mode bit written any time
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) cfg_mode <= 1'b0;
    else if (i_mode_wr) cfg_mode <= i_mode_config_en;
  end

  // Settings written only while configuring
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oc_thr <= `GDFP_THR_RST;
      oc_filt <= `GDFP_FILT_RST;
      sc_thr <= `GDFP_THR_RST;
      sc_filt <= `GDFP_FILT_RST;
      dead <= `GDFP_DEAD_RST;
      vge_dly <= `GDFP_VGE_DLY_RST;
    end else if (i_cfg_wr && cfg_mode) begin
      oc_thr <= i_overcurrent_thr;
      oc_filt <= i_overcurrent_filt;
      sc_thr <= i_short_circuit_thr;
      sc_filt <= i_short_circuit_filt;
      dead <= i_dead_time_config;
      vge_dly <= i_gate_monitor_config;
    end
  end

  // Mask writes outside configuration mode are dropped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) msk <= `GDFP_MASK_RST;
    else if (i_mask_wr && cfg_mode) msk <= i_fault_mask_two;
  end

  //////////////////////////////////////////////////////////////////////
  // Pin qualification
  logic pwm_l;
  logic alt_l;
  logic fsn_l;
  logic vge_l;
  logic sc_l;
  logic oc_l;
  logic dla_l;
  logic dlb_l;
  logic csb_l;
  logic sel_l;
  logic sc_hit;
  logic oc_hit;

  assign sc_hit = i_current_code >= sc_thr;
  assign oc_hit = i_current_code >= oc_thr;

  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_pwm (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(i_pwm), .i_len(8'h00), .o_level(pwm_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_alt (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(i_pwm_alt), .i_len(8'h00), .o_level(alt_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_fsn (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(i_failsafe_enable_n), .i_len(8'h00), .o_level(fsn_l)
  );
  // Gate monitor delay filters short gate dips
  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_vge (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(i_gate_voltage_monitor), .i_len(vge_dly), .o_level(vge_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b0)) u_sc (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(sc_hit), .i_len(sc_filt), .o_level(sc_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b0)) u_oc (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(oc_hit), .i_len(oc_filt), .o_level(oc_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_dla (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(i_die_low_ready), .i_len(8'h00), .o_level(dla_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_dlb (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(i_die_high_ready), .i_len(8'h00), .o_level(dlb_l)
  );
  gdfp_pin_filt #(.W(8), .SYNC(1'b1)) u_csb (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_raw(!i_csb_n), .i_len(8'h00), .o_level(sel_l)
  );
  assign csb_l = !sel_l; // Reads idle from reset, so no false edge arms the gap check

  //////////////////////////////////////////////////////////////////////
  // Dead time
  logic drive;
  logic dt_viol;

  gdfp_dead_time #(.W(8)) u_dt (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pwm(pwm_l),
    .i_pwm_alt(alt_l),
    .i_dead(dead),
    .o_drive(drive),
    .o_violation(dt_viol)
  );

  //////////////////////////////////////////////////////////////////////
  // Serial link, on the serial clock
  logic fresh;
  logic [4:0] bitn;
  logic [7:0] crc;
  logic bad;
  logic [4:0] bitn_b;
  logic [7:0] crc_b;
  logic [7:0] next_crc;

  // Chip select high marks the next edge as a frame start
  always_ff @(posedge i_sclk or posedge i_csb_n or negedge i_rstn) begin
    if (!i_rstn) fresh <= 1'b1;
    else if (i_csb_n) fresh <= 1'b1;
    else fresh <= 1'b0;
  end

  assign bitn_b = fresh ? 5'h00 : bitn;
  assign crc_b = (fresh || bitn == 5'h00) ? 8'h00 : crc;
  assign next_crc = {crc_b[6:0], 1'b0} ^ ((crc_b[7] ^ i_mosi) ? `GDFP_CRC_POLY : 8'h00);

  // Counts are held after the frame so the core can read them
  always_ff @(posedge i_sclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bitn <= 5'h00;
      crc <= 8'h00;
      bad <= 1'b0;
    end else begin
      crc <= next_crc;
      if (bitn_b == `GDFP_FRAME_BITS - 5'h01) bitn <= 5'h00;
      else bitn <= bitn_b + 5'h01;
      if (bitn_b == `GDFP_FRAME_BITS - 5'h01 && next_crc != 8'h00) bad <= 1'b1;
      else if (fresh) bad <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Serial checks, on the core clock
  logic csb_q;
  logic csb_rise;
  logic csb_fall;
  logic [15:0] gap;
  logic gap_arm;
  gdfp_chk_t chk;
  logic [15:0] init_cnt;
  logic spi_ev;
  logic len_ev;
  logic gap_ev;
  logic init_ev;

  assign csb_rise = csb_l && !csb_q;
  assign csb_fall = !csb_l && csb_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) csb_q <= 1'b1;
    else csb_q <= csb_l;
  end

  // Link clock has stopped by the time the rise is qualified here
  assign len_ev = csb_rise && (bitn != 5'h00 || bad);

  // High time since last frame, saturating
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap <= 16'hFFFF;
      gap_arm <= 1'b0;
    end else begin
      if (csb_rise) gap_arm <= 1'b1;
      if (!csb_l) gap <= 16'h0000;
      else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
    end
  end

  assign gap_ev = csb_fall && gap_arm && gap < 16'(CS_GAP_CYC);

  // Chip select must read idle once start-up settles
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chk <= GDFP_CHK_INIT;
      init_cnt <= 16'h0000;
    end else begin
      case (chk)
        GDFP_CHK_INIT: begin
          if (init_cnt == `GDFP_INIT_CYC) chk <= GDFP_CHK_RUN;
          else init_cnt <= init_cnt + 16'h0001;
        end
        GDFP_CHK_RUN: chk <= GDFP_CHK_RUN;
        default: chk <= GDFP_CHK_INIT;
      endcase
    end
  end

  assign init_ev = chk == GDFP_CHK_INIT && init_cnt == `GDFP_INIT_CYC && !csb_l;
  assign spi_ev = len_ev || gap_ev || init_ev;

  //////////////////////////////////////////////////////////////////////
  // Die watchdog
  logic [15:0] wd_cnt;
  logic wd_arm;
  logic wd_ev;

  // Armed until both dies have been seen ready together
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_cnt <= 16'h0000;
      wd_arm <= 1'b1;
    end else begin
      if (dla_l && dlb_l) wd_arm <= 1'b0;
      if (wd_arm && (dla_l ^ dlb_l) && wd_cnt != 16'(WDOG_CYC)) wd_cnt <= wd_cnt + 16'h0001;
      else if (!(dla_l ^ dlb_l)) wd_cnt <= 16'h0000;
    end
  end

  assign wd_ev = wd_arm && wd_cnt == 16'(WDOG_CYC) - 16'h0001;

  //////////////////////////////////////////////////////////////////////
  // Sticky fault flags; a set in the clear cycle wins
  logic sc_f;
  logic oc_f;
  logic vge_f;
  logic dt_f;
  logic wd_f;
  logic spi_f;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sc_f <= 1'b0;
      oc_f <= 1'b0;
    end else begin
      sc_f <= sc_l || (sc_f && !i_clear_one[`GDFP_S1_SC]);
      oc_f <= oc_l || (oc_f && !i_clear_one[`GDFP_S1_OC]);
    end
  end

  // Masked faults are not latched at all
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vge_f <= 1'b0;
      dt_f <= 1'b0;
      wd_f <= 1'b0;
      spi_f <= 1'b0;
    end else begin
      vge_f <= (vge_l && msk[`GDFP_M2_VGE]) || (vge_f && !i_clear_two[`GDFP_S2_VGE]);
      dt_f <= (dt_viol && msk[`GDFP_M2_DT]) || (dt_f && !i_clear_two[`GDFP_S2_DT]);
      wd_f <= wd_ev || (wd_f && !i_clear_two[`GDFP_S2_WDOG]);
      spi_f <= spi_ev || (spi_f && !i_clear_two[`GDFP_S2_SPI]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Gate and status outputs
  logic allow;

  // Overcurrent and dead time flags never gate the drive
  assign allow = fsn_l && !cfg_mode && !sc_f && !vge_f;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_gate <= 1'b0;
    else o_gate <= drive && allow;
  end

  // Status mirrors, all registered
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mode_control_two <= 1'b0;
      o_fault_mask_two <= `GDFP_MASK_RST;
      o_fault_status_one <= 2'h0;
      o_fault_status_two <= 4'h0;
      o_fault_status_three <= 1'h0;
    end else begin
      o_mode_control_two <= cfg_mode;
      o_fault_mask_two <= msk;
      o_fault_status_one <= {oc_f, sc_f};
      o_fault_status_two <= {spi_f, wd_f, dt_f, vge_f};
      o_fault_status_three <= fsn_l;
    end
  end
endmodule : gdfp_gating
`default_nettype wire

// file: hdl/gdfp_consts.svh
// Purpose: Shared constants of the gate driver fault and gating block
// Assumes: 250 MHz core clock
// Notes: Bit positions index the status, mask and clear vectors
`ifndef GDFP_CONSTS_SVH
`define GDFP_CONSTS_SVH
// Timing
`define GDFP_CLK_NS 4
`define GDFP_CS_GAP_NS 19000
`define GDFP_INIT_CYC 16'h0010
`define GDFP_WDOG_CYC 256
// Serial frame
`define GDFP_FRAME_BITS 5'h18
`define GDFP_CRC_POLY 8'h07
// Status one layout
`define GDFP_S1_SC 0
`define GDFP_S1_OC 1
// Status two layout
`define GDFP_S2_VGE 0
`define GDFP_S2_DT 1
`define GDFP_S2_WDOG 2
`define GDFP_S2_SPI 3
// Mask two layout, 1 = fault active
`define GDFP_M2_VGE 0
`define GDFP_M2_DT 1
`define GDFP_MASK_RST 2'h3
// Configuration reset values
`define GDFP_THR_RST 8'h80
`define GDFP_FILT_RST 8'h04
`define GDFP_DEAD_RST 8'h10
`define GDFP_VGE_DLY_RST 8'h08
`endif

// file: hdl/gdfp_pkg.sv
// Purpose: Types of the gate driver fault and gating block
// Assumes: Nothing beyond the constants header
// Notes: Constants live in gdfp_consts.svh
package gdfp_pkg;
  // Eight bit configuration code
  typedef logic [7:0] gdfp_code_t;
  // Start-up serial check
  typedef enum logic [0:0] {
    GDFP_CHK_INIT,
    GDFP_CHK_RUN
  } gdfp_chk_t;
endpackage : gdfp_pkg

// file: hdl/gdfp_pin_filt.sv
// Purpose: Input synchroniser with persistence filter
// Assumes: i_len is steady while a change is being qualified
// Notes: SYNC=0 for inputs already on i_clk
`timescale 1ns/1ps
`default_nettype none
module gdfp_pin_filt #(
  parameter int W = 8,
  parameter bit SYNC = 1'b1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Raw level and persistence length
  input wire logic i_raw,
  input wire logic [W-1:0] i_len,
  // Qualified level
  output logic o_level
);
  logic [2:0] sr;
  logic [W-1:0] cnt;
  logic cand;
  logic ok;

  // Three flop chain; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) sr <= 3'h0;
    else sr <= {sr[1:0], i_raw};
  end

  assign cand = SYNC ? sr[2] : i_raw;
  assign ok = SYNC ? (sr[1] == sr[2]) : 1'b1;

  // Change must persist i_len+1 qualified cycles; shorter glitches never reach o_level
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
      o_level <= 1'b0;
    end else if (ok && cand != o_level) begin
      if (cnt >= i_len) begin
        cnt <= '0;
        o_level <= cand;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end else begin
      cnt <= '0;
    end
  end
endmodule : gdfp_pin_filt
`default_nettype wire

// file: hdl/gdfp_dead_time.sv
// Purpose: Dead time enforcement for one gate command
// Assumes: i_pwm and i_pwm_alt already qualified on i_clk
// Notes: Turn-on waits i_dead cycles after the opposite side goes low
`timescale 1ns/1ps
`default_nettype none
module gdfp_dead_time #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Commands and required gap
  input wire logic i_pwm,
  input wire logic i_pwm_alt,
  input wire logic [W-1:0] i_dead,
  // Enforced drive and violation pulse
  output logic o_drive,
  output logic o_violation
);
  logic [W-1:0] since;
  logic pwm_q;
  logic alt_q;
  logic gap_ok;

  assign gap_ok = !i_pwm_alt && since >= i_dead;

  // Cycles since the opposite side went low, saturating
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) since <= '1;
    else if (i_pwm_alt) since <= '0;
    else if (since != '1) since <= since + 1'b1;
  end

  // Drive only after a clean gap; turn-off is never delayed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_drive <= 1'b0;
    else o_drive <= i_pwm && (o_drive ? !i_pwm_alt : gap_ok);
  end

  // Overlap or short gap from the commands is reported
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_q <= 1'b0;
      alt_q <= 1'b0;
      o_violation <= 1'b0;
    end else begin
      pwm_q <= i_pwm;
      alt_q <= i_pwm_alt;
      o_violation <= (i_pwm && !pwm_q && !gap_ok) || (i_pwm_alt && !alt_q && i_pwm);
    end
  end
endmodule : gdfp_dead_time
`default_nettype wire

// file: verification/gdfp_gating_monitor.sv
// Purpose: Port-level checker for the gate driver fault and gating block
// Assumes: Status, mode and mask outputs lag their cause by two edges
// Notes: Bound to every gdfp_gating instance
`timescale 1ns/1ps
`default_nettype none
module gdfp_gating_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Watched inputs
  input wire logic i_failsafe_enable_n,
  input wire logic i_mode_wr,
  input wire logic i_mode_config_en,
  input wire logic i_mask_wr,
  input wire logic [1:0] i_fault_mask_two,
  input wire logic [1:0] i_clear_one,
  input wire logic [3:0] i_clear_two,
  // Watched outputs
  input wire logic o_gate,
  input wire logic o_mode_control_two,
  input wire logic [1:0] o_fault_mask_two,
  input wire logic [1:0] o_fault_status_one,
  input wire logic [3:0] o_fault_status_two,
  input wire logic [0:0] o_fault_status_three
);
  default clocking mon_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////
  // Write requests; a mode write one edge earlier hides the live mode
  sequence s_mode_req;
    i_mode_wr;
  endsequence
  sequence s_mask_req;
    i_mask_wr && o_mode_control_two && !$past(i_mode_wr);
  endsequence
  ////////////////////////////////////////////////////////////////
  // Register writes land two edges later
  AST_MODE_WR: assert property (s_mode_req |-> ##2 o_mode_control_two == $past(i_mode_config_en, 2))
    else $error("mode bit missed its write");
  AST_MASK_WR: assert property (s_mask_req |-> ##2 o_fault_mask_two == $past(i_fault_mask_two, 2))
    else $error("mask missed its write");
  // Gate blocking and status three, margins cover sync and output latency
  AST_FS_BLOCK: assert property (!i_failsafe_enable_n [*8] |-> !o_gate)
    else $error("gate on with fail-safe enable low");
  AST_MODE_BLOCK: assert property (o_mode_control_two [*3] |-> !o_gate)
    else $error("gate on in configuration mode");
  AST_SC_BLOCK: assert property (o_fault_status_one[0] [*3] |-> !o_gate)
    else $error("gate on with short circuit latched");
  AST_VGE_BLOCK: assert property (o_fault_status_two[0] [*3] |-> !o_gate)
    else $error("gate on with gate voltage fault latched");
  AST_FS_STATUS: assert property ($stable(i_failsafe_enable_n) [*8] |-> o_fault_status_three[0] == i_failsafe_enable_n)
    else $error("status three differs from enable pin");
  // Flags only fall after a clear pulse two edges back
  AST_SC_HOLD: assert property ($fell(o_fault_status_one[0]) |-> $past(i_clear_one[0], 2))
    else $error("short circuit flag fell without clear");
  AST_OC_HOLD: assert property ($fell(o_fault_status_one[1]) |-> $past(i_clear_one[1], 2))
    else $error("overcurrent flag fell without clear");
  AST_SERR_HOLD: assert property ($fell(o_fault_status_two[3]) |-> $past(i_clear_two[3], 2))
    else $error("serial error fell without clear");
endmodule : gdfp_gating_monitor
bind gdfp_gating gdfp_gating_monitor u_monitor (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_failsafe_enable_n(i_failsafe_enable_n), .i_mode_wr(i_mode_wr), .i_mode_config_en(i_mode_config_en),
  .i_mask_wr(i_mask_wr), .i_fault_mask_two(i_fault_mask_two), .i_clear_one(i_clear_one),
  .i_clear_two(i_clear_two), .o_gate(o_gate), .o_mode_control_two(o_mode_control_two),
  .o_fault_mask_two(o_fault_mask_two), .o_fault_status_one(o_fault_status_one),
  .o_fault_status_two(o_fault_status_two), .o_fault_status_three(o_fault_status_three));
`default_nettype wire

// file: verification/gdfp_host_model.sv
// Purpose: Host side of the serial link, frames on its own clock
// Assumes: 64 ns serial period, clock still between frames
// Notes: Bit count, CRC fault and frame gap are chosen per call
`timescale 1ns/1ps
`default_nettype none
module gdfp_host_model (
  // Serial pins toward the device
  output logic o_sclk,
  output logic o_csb_n,
  output logic o_mosi
);
  logic [23:0] word;
  initial begin
    o_sclk = 1'h0;
    o_csb_n = 1'h1;
    o_mosi = 1'h1;
  end
  // CRC-8 poly 07, zero start, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  // One frame; odd fractional start keeps edges off the core grid
  task automatic send(input int n, input logic bad, input int gap_ns);
    #(gap_ns + 3.3);
    o_csb_n = 1'h0;
    #32;
    for (int i = 0; i < n; i++) begin
      if (i % 24 == 0) word = {16'hC35A ^ i[15:0], crc8(16'hC35A ^ i[15:0]) ^ {7'h00, bad}};
      o_mosi = word[23 - i % 24];
      #32 o_sclk = 1'h1;
      #32 o_sclk = 1'h0;
    end
    #64 o_csb_n = 1'h1;
    o_mosi = ~o_mosi; // Released line must not look held
  endtask : send
  // Select held as an open or late host would leave it
  task automatic hold_select(input logic v);
    o_csb_n = v;
  endtask : hold_select
endmodule : gdfp_host_model
`default_nettype wire

// file: verification/tb_gdfp_gating.sv
// Purpose: Self-checking bench of the fault and gating block
// Assumes: Short gap of 40 cycles and watchdog of 16 cycles
// Notes: Inputs other than the host serial pins change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module tb_gdfp_gating;
  typedef struct {logic fs_n, cfg, pwm, bad, gate, serr; int nbits, gap;} gdfp_row_t;
  logic i_clk = 1'h0;
  logic i_rstn, i_pwm, i_pwm_alt, i_failsafe_enable_n, i_gate_voltage_monitor;
  logic i_die_low_ready, i_die_high_ready, i_sclk, i_csb_n, i_mosi;
  logic i_mode_wr, i_mode_config_en, i_cfg_wr, i_mask_wr, o_gate, o_mode_control_two;
  logic [7:0] i_current_code, i_overcurrent_thr, i_overcurrent_filt, i_short_circuit_thr;
  logic [7:0] i_short_circuit_filt, i_dead_time_config, i_gate_monitor_config;
  logic [1:0] i_fault_mask_two, i_clear_one, o_fault_mask_two, o_fault_status_one;
  logic [3:0] i_clear_two, o_fault_status_two;
  logic [0:0] o_fault_status_three;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  // Frame cases: enable, mode, pwm, bad CRC, gate, serial error, bits, gap
  gdfp_row_t rows[5] = '{'{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 24, 400},
    '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 48, 400}, '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 23, 400},
    '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 24, 400}, '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 24, 0}};
  always #2 i_clk = ~i_clk;
  gdfp_gating #(.CS_GAP_CYC(40), .WDOG_CYC(16)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_pwm(i_pwm),
    .i_pwm_alt(i_pwm_alt), .i_failsafe_enable_n(i_failsafe_enable_n),
    .i_gate_voltage_monitor(i_gate_voltage_monitor), .i_current_code(i_current_code),
    .i_die_low_ready(i_die_low_ready), .i_die_high_ready(i_die_high_ready), .i_sclk(i_sclk),
    .i_csb_n(i_csb_n), .i_mosi(i_mosi), .i_mode_wr(i_mode_wr), .i_mode_config_en(i_mode_config_en),
    .i_cfg_wr(i_cfg_wr), .i_overcurrent_thr(i_overcurrent_thr), .i_overcurrent_filt(i_overcurrent_filt),
    .i_short_circuit_thr(i_short_circuit_thr), .i_short_circuit_filt(i_short_circuit_filt),
    .i_dead_time_config(i_dead_time_config), .i_gate_monitor_config(i_gate_monitor_config),
    .i_mask_wr(i_mask_wr), .i_fault_mask_two(i_fault_mask_two), .i_clear_one(i_clear_one),
    .i_clear_two(i_clear_two), .o_gate(o_gate), .o_mode_control_two(o_mode_control_two),
    .o_fault_mask_two(o_fault_mask_two), .o_fault_status_one(o_fault_status_one),
    .o_fault_status_two(o_fault_status_two), .o_fault_status_three(o_fault_status_three));
  gdfp_host_model host (.o_sclk(i_sclk), .o_csb_n(i_csb_n), .o_mosi(i_mosi));
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Writes are one-cycle pulses, then time for the two-edge latency
  task automatic wr_mode(input logic v);
    i_mode_config_en = v;
    i_mode_wr = 1'h1;
    tick(1);
    i_mode_wr = 1'h0;
    tick(3);
  endtask : wr_mode
  task automatic wr_mask(input logic [1:0] v);
    i_fault_mask_two = v;
    i_mask_wr = 1'h1;
    tick(1);
    i_mask_wr = 1'h0;
    tick(3);
  endtask : wr_mask
  task automatic cfg(input logic [7:0] ot, input logic [7:0] of, input logic [7:0] st, input logic [7:0] sf);
    {i_overcurrent_thr, i_overcurrent_filt, i_short_circuit_thr, i_short_circuit_filt} = {ot, of, st, sf};
    {i_dead_time_config, i_gate_monitor_config} = 16'h0402;
    i_cfg_wr = 1'h1;
    tick(1);
    i_cfg_wr = 1'h0;
    tick(3);
  endtask : cfg
  task automatic clr(input logic [1:0] a, input logic [3:0] b);
    {i_clear_one, i_clear_two} = {a, b};
    tick(1);
    {i_clear_one, i_clear_two} = 6'h00;
    tick(3);
  endtask : clr
  task automatic chk_reset();
    chk({1'h0, o_gate, o_mode_control_two, o_fault_mask_two, o_fault_status_one, o_fault_status_three}, 8'h18, "reset");
    chk({4'h0, o_fault_status_two}, 8'h00, "reset status two");
  endtask : chk_reset
  // Hang guard, a few times the expected length
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {i_pwm, i_pwm_alt, i_gate_voltage_monitor, i_mode_wr, i_mode_config_en, i_cfg_wr, i_mask_wr} = 7'h00;
    {i_rstn, i_die_high_ready, i_fault_mask_two, i_clear_one, i_clear_two} = 10'h000;
    {i_failsafe_enable_n, i_die_low_ready, i_current_code} = 10'h300;
    {i_overcurrent_thr, i_overcurrent_filt, i_short_circuit_thr} = 24'h000000;
    {i_short_circuit_filt, i_dead_time_config, i_gate_monitor_config} = 24'h000000;
    tick(12);
    i_rstn = 1'h1;
    chk_reset();
    // One die up alone; select idle high so no start-up serial error
    tick(40);
    chk({4'h0, o_fault_status_two}, 8'h04, "watchdog");
    i_die_high_ready = 1'h1;
    clr(2'h0, 4'h4);
    chk({4'h0, o_fault_status_two}, 8'h00, "watchdog clear");
    foreach (rows[k]) begin
      {i_failsafe_enable_n, i_pwm} = {rows[k].fs_n, rows[k].pwm};
      wr_mode(rows[k].cfg);
      host.send(rows[k].nbits, rows[k].bad, rows[k].gap);
      tick(20);
      chk({4'h0, o_mode_control_two, o_gate, o_fault_status_three, o_fault_status_two[3]},
        {4'h0, rows[k].cfg, rows[k].gate, rows[k].fs_n, rows[k].serr}, "row");
      clr(2'h0, 4'h8);
    end
    // Thresholds ignored outside configuration mode
    cfg(8'h10, 8'h00, 8'h10, 8'h06);
    i_current_code = 8'h20;
    tick(20);
    chk({6'h00, o_fault_status_one}, 8'h00, "refused config");
    wr_mode(1'h1);
    cfg(8'h20, 8'h00, 8'h40, 8'h06);
    wr_mode(1'h0);
    i_current_code = 8'h30;
    tick(20);
    chk({5'h00, o_fault_status_one, o_gate}, 8'h05, "overcurrent");
    i_current_code = 8'h40;
    tick(4);
    i_current_code = 8'h30;
    tick(10);
    chk({6'h00, o_fault_status_one}, 8'h02, "short filter");
    i_current_code = 8'h40;
    tick(20);
    i_current_code = 8'h00;
    tick(20);
    chk({5'h00, o_fault_status_one, o_gate}, 8'h06, "short circuit");
    clr(2'h3, 4'h0);
    tick(20);
    chk({5'h00, o_fault_status_one, o_gate}, 8'h01, "faults cleared");
    // Clear loses while the gate voltage cause persists
    i_gate_voltage_monitor = 1'h1;
    tick(20);
    clr(2'h0, 4'h1);
    chk({6'h00, o_fault_status_two[0], o_gate}, 8'h02, "gate voltage");
    i_gate_voltage_monitor = 1'h0;
    tick(20);
    clr(2'h0, 4'h1);
    chk({6'h00, o_fault_status_two[0], o_gate}, 8'h01, "gate voltage clear");
    wr_mask(2'h0);
    chk({6'h00, o_fault_mask_two}, 8'h03, "refused mask");
    wr_mode(1'h1);
    wr_mask(2'h2);
    wr_mode(1'h0);
    i_gate_voltage_monitor = 1'h1;
    tick(20);
    chk({5'h00, o_fault_mask_two, o_fault_status_two[0]}, 8'h04, "masked gate voltage");
    chk({7'h00, o_gate}, 8'h01, "masked gate voltage drive");
    i_gate_voltage_monitor = 1'h0;
    // Turn-on while the opposite side is high
    i_pwm = 1'h0;
    tick(20);
    i_pwm_alt = 1'h1;
    tick(10);
    i_pwm = 1'h1;
    tick(20);
    chk({6'h00, o_fault_status_two[1], o_gate}, 8'h02, "dead time");
    i_pwm_alt = 1'h0;
    tick(7);
    chk({7'h00, o_gate}, 8'h00, "dead gap");
    tick(5);
    chk({7'h00, o_gate}, 8'h01, "after gap");
    clr(2'h0, 4'h2);
    wr_mode(1'h1);
    wr_mask(2'h1);
    wr_mode(1'h0);
    tick(20);
    i_pwm_alt = 1'h1;
    tick(20);
    chk({6'h00, o_fault_mask_two[1], o_fault_status_two[1]}, 8'h00, "masked dead time");
    // Second reset with select left low, as an absent host would
    {i_pwm_alt, i_rstn} = 2'h0;
    tick(2);
    chk_reset();
    host.hold_select(1'h0);
    i_rstn = 1'h1;
    tick(30);
    chk({7'h00, o_fault_status_two[3]}, 8'h01, "open bus");
    stop_test();
  end
endmodule : tb_gdfp_gating
`default_nettype wire
